//--- hdl/idbc_pkg.sv
// constants shared by the interleaved dram burst controller
package idbc_pkg;
	// each bank counter: one phase bit plus seven bank address bits
	localparam int BANK_COUNT = 2;
	localparam int CNT_W = 8;
	localparam int BANK_ADDR_W = 7;
	localparam int LSB_POS = 0;
	localparam int UPPER_LO = 1;
	localparam int UPPER_HI = 7;
	localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;
	localparam logic [BANK_ADDR_W-1:0] UPPER_STEP = 7'h01;
	localparam logic FLAG_RESET = 1'b0;

	// access state machine, one-hot
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_INSTR_ROW_STROBE_STATE = 6'h02,
		ST_IACC = 6'h04,
		ST_DRAS = 6'h08,
		ST_DACC = 6'h10,
		ST_PREC = 6'h20
	} idbc_state_t;
	localparam idbc_state_t STATE_RESET = ST_IDLE;
endpackage : idbc_pkg

//--- hdl/idbc_ctrl.sv
// burst acknowledge, access sequencers, precharge and bank address counters
`timescale 1ns/100ps

// Contract
// - instruction ack sets cycle after start with bus valid, holds until exit.
// - ack set term uses undelayed bus-invalid input since start is combinational.
// - instruction ack tells processor the address is captured.
// - ack holds through exit cycle of a new access; data and refresh wait.
// - delayed copies of both burst acks, one clock after the originals.
// - data ack built like instruction ack from data start and exit.
// - internal data ack follows data ack and holds through preempt stages.
// - first instruction phase flag lasts three cycles; set by start or resume.
// - second and third instruction phase flags follow; third is last cycle.
// - three data phase flags sequence like the instruction ones.
// - refresh-preempted write burst finishes two more writes before precharge.
// - preempt starts on write, burst request, post-initial, refresh, not stage b.
// - row strobe drops at end of every access to precharge.
// - precharge takes two cycles: first flag then second flag.
// - first precharge set by instr exit, data exit, refresh end, last preempt.
// - load strobe loads counters next edge; cross-side requests blocked.
// - load strobe lasts at most one cycle.
// - load strobe is combinational, active in first request cycle.
// - one address counter per bank, lsb phase bit carries into upper seven bits.
// - counter lsb gates upper seven bits; only those drive bank address.
// - instruction start moves state from idle to instruction row strobe.
module idbc_ctrl (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	// processor bus
	input wire logic bus_invalid_i,
	input wire logic instr_request_i,
	input wire logic data_request_i,
	input wire logic data_write_i,
	input wire logic data_burst_req_delayed_i,
	// terms from neighbouring logic
	input wire logic instr_access_begin_i,
	input wire logic data_access_begin_i,
	input wire logic instr_access_leave_i,
	input wire logic instr_block_hit_i,
	input wire logic refresh_pending_i,
	input wire logic refresh_final_phase_i,
	// address counters
	input wire logic [idbc_pkg::BANK_COUNT-1:0] bank_count_i,
	input wire logic [idbc_pkg::CNT_W-1:0] load_addr_i [idbc_pkg::BANK_COUNT],
	// acknowledges
	output logic instr_burst_ack_o,
	output logic data_burst_ack_o,
	output logic data_ack_internal_o,
	output logic instr_ack_delayed_o,
	output logic data_ack_delayed_o,
	// sequencer flags
	output logic [2:0] instr_init_phase_o,
	output logic [2:0] data_init_phase_o,
	output logic [1:0] write_preempt_stage_o,
	output logic precharge_first_o,
	output logic precharge_second_o,
	output logic row_strobe_o,
	output idbc_pkg::idbc_state_t access_state_o,
	// bank addresses and phase bits
	output logic [idbc_pkg::BANK_ADDR_W-1:0] bank_addr_o [idbc_pkg::BANK_COUNT],
	output logic [idbc_pkg::BANK_COUNT-1:0] bank_lsb_o
);

	// three-stage phase shifter shared by the instruction and data sides
	function automatic logic [2:0] phase_step(input logic [2:0] q,
			input logic set);
		phase_step = {q[1] & ~q[2], q[0] & ~q[2], set | (q[0] & ~q[2])};
	endfunction : phase_step

	// acknowledges and flags
	logic instr_burst_ack, data_burst_ack, data_ack_internal, instr_ack_delayed, data_ack_delayed;
	logic next_instr_burst_ack, next_data_burst_ack, next_data_ack_internal;
	logic [2:0] iq, dq, next_iq, next_dq;
	logic wp_a, wp_b, next_wp_a, next_wp_b;
	logic pc1, pc2, next_pc1, next_pc2;
	logic row, next_row;
	idbc_pkg::idbc_state_t state, next_state;
	logic [idbc_pkg::CNT_W-1:0] cnt [idbc_pkg::BANK_COUNT];
	logic [idbc_pkg::CNT_W-1:0] next_cnt [idbc_pkg::BANK_COUNT];

	// combinational terms
	logic bus_valid, data_access_begin_q, data_access_leave, preempt_begin, load_strobe;

	always_comb begin
		bus_valid = ~bus_invalid_i;
		// a held instruction ack keeps data off this memory
		data_access_begin_q = data_access_begin_i & ~instr_burst_ack;
		data_access_leave = ~data_ack_internal
			| (~dq[0] & ~pc1 & ~pc2
			& (instr_block_hit_i | refresh_pending_i));
		preempt_begin = data_ack_internal & data_write_i & data_burst_req_delayed_i
			& refresh_pending_i & ~dq[0] & ~wp_b;
		// combinational so the first request cycle already loads; the
		// phase and precharge gating keep it to a single cycle
		load_strobe = (~iq[0] & ~data_ack_internal & instr_request_i
			& (~instr_burst_ack | pc1))
			| (~dq[0] & ~instr_burst_ack & data_request_i
			& (~data_ack_internal | pc1));
	end

	always_comb begin
		// start qualified by the live bus-invalid, not its delayed copy
		next_instr_burst_ack = (bus_valid & instr_access_begin_i)
			| (instr_burst_ack & ~instr_access_leave_i);
		next_data_burst_ack = (bus_valid & data_access_begin_q) | (data_burst_ack & ~data_access_leave);
		next_data_ack_internal = (bus_valid & data_access_begin_q) | (data_ack_internal & ~data_access_leave)
			| preempt_begin;
		next_iq = phase_step(iq, (bus_valid & instr_access_begin_i
			& ~instr_burst_ack) | (~pc1 & pc2 & instr_burst_ack));
		next_dq = phase_step(dq, (bus_valid & data_access_begin_q & ~data_burst_ack)
			| (~pc1 & pc2 & data_burst_ack));
		next_wp_a = preempt_begin;
		next_wp_b = ~wp_b & wp_a;
		next_pc1 = (~pc1 & instr_burst_ack & instr_access_leave_i)
			| (~pc1 & data_ack_internal & ~preempt_begin & data_access_leave)
			| (~pc1 & refresh_final_phase_i) | wp_b;
		next_pc2 = pc1 & ~pc2;
	end

	always_comb begin
		next_state = state;
		unique case (state)
			idbc_pkg::ST_IDLE: begin
				if (bus_valid & instr_access_begin_i)
					next_state = idbc_pkg::ST_INSTR_ROW_STROBE_STATE;
				else if (bus_valid & data_access_begin_q)
					next_state = idbc_pkg::ST_DRAS;
			end
			idbc_pkg::ST_INSTR_ROW_STROBE_STATE: begin
				if (iq[2])
					next_state = idbc_pkg::ST_IACC;
			end
			idbc_pkg::ST_DRAS: begin
				if (dq[2])
					next_state = idbc_pkg::ST_DACC;
			end
			idbc_pkg::ST_IACC, idbc_pkg::ST_DACC: begin
				if (next_pc1)
					next_state = idbc_pkg::ST_PREC;
			end
			idbc_pkg::ST_PREC: begin
				next_state = idbc_pkg::ST_IDLE;
			end
			default: next_state = idbc_pkg::ST_IDLE;
		endcase
		if (next_pc1 && state != idbc_pkg::ST_PREC)
			next_state = idbc_pkg::ST_PREC;
		// registered from the next state so the pin carries no decode glitch
		next_row = (next_state == idbc_pkg::ST_INSTR_ROW_STROBE_STATE)
			| (next_state == idbc_pkg::ST_IACC)
			| (next_state == idbc_pkg::ST_DRAS)
			| (next_state == idbc_pkg::ST_DACC);
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			instr_burst_ack <= idbc_pkg::FLAG_RESET;
			data_burst_ack <= idbc_pkg::FLAG_RESET;
			data_ack_internal <= idbc_pkg::FLAG_RESET;
			instr_ack_delayed <= idbc_pkg::FLAG_RESET;
			data_ack_delayed <= idbc_pkg::FLAG_RESET;
			iq <= '0;
			dq <= '0;
			wp_a <= idbc_pkg::FLAG_RESET;
			wp_b <= idbc_pkg::FLAG_RESET;
			pc1 <= idbc_pkg::FLAG_RESET;
			pc2 <= idbc_pkg::FLAG_RESET;
			row <= idbc_pkg::FLAG_RESET;
			state <= idbc_pkg::STATE_RESET;
		end else begin
			instr_burst_ack <= next_instr_burst_ack;
			data_burst_ack <= next_data_burst_ack;
			data_ack_internal <= next_data_ack_internal;
			instr_ack_delayed <= instr_burst_ack;
			data_ack_delayed <= data_burst_ack;
			iq <= next_iq;
			dq <= next_dq;
			wp_a <= next_wp_a;
			wp_b <= next_wp_b;
			pc1 <= next_pc1;
			pc2 <= next_pc2;
			row <= next_row;
			state <= next_state;
		end
	end

	// per-bank counters; the upper bits only move when the phase bit is
	// set, which keeps the two banks one word out of step
	genvar b;
	generate
		for (b = 0; b < idbc_pkg::BANK_COUNT; b++) begin : g_bank
			logic step, carry;
			always_comb begin
				// counting is suppressed while the bus is invalid
				step = bank_count_i[b] & bus_valid;
				carry = cnt[b][idbc_pkg::LSB_POS];
				next_cnt[b] = cnt[b];
				if (load_strobe) begin
					next_cnt[b] = load_addr_i[b];
				end else if (step) begin
					next_cnt[b][idbc_pkg::LSB_POS] = ~carry;
					if (carry)
						next_cnt[b][idbc_pkg::UPPER_HI:idbc_pkg::UPPER_LO] =
							cnt[b][idbc_pkg::UPPER_HI:idbc_pkg::UPPER_LO]
							+ idbc_pkg::UPPER_STEP;
				end
			end
			always_ff @(posedge ref_clk_i) begin
				if (sys_rst_i)
					cnt[b] <= idbc_pkg::CNT_RESET;
				else
					cnt[b] <= next_cnt[b];
			end
			assign bank_addr_o[b] =
				cnt[b][idbc_pkg::UPPER_HI:idbc_pkg::UPPER_LO];
			assign bank_lsb_o[b] = cnt[b][idbc_pkg::LSB_POS];
		end
	endgenerate

	assign instr_burst_ack_o = instr_burst_ack;
	assign data_burst_ack_o = data_burst_ack;
	assign data_ack_internal_o = data_ack_internal;
	assign instr_ack_delayed_o = instr_ack_delayed;
	assign data_ack_delayed_o = data_ack_delayed;
	assign instr_init_phase_o = iq;
	assign data_init_phase_o = dq;
	assign write_preempt_stage_o = {wp_b, wp_a};
	assign precharge_first_o = pc1;
	assign precharge_second_o = pc2;
	// row strobe is high in the row and access states, low in precharge
	assign row_strobe_o = row;
	assign access_state_o = state;

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (sys_rst_i);

	sequence s_istart;
		bus_valid && instr_access_begin_i;
	endsequence
	sequence s_iphase_run;
		iq[0] ##1 (iq[0] && iq[1]) ##1 (iq[0] && iq[1] && iq[2])
			##1 !iq[0];
	endsequence
	sequence s_preempt_run;
		wp_a ##1 wp_b ##1 pc1;
	endsequence

	AST_IACK_SET: assert property (s_istart |=> instr_burst_ack)
		else $error("instruction ack not set after start");
	AST_IACK_HOLD: assert property (
		instr_burst_ack && !instr_access_leave_i |=> instr_burst_ack)
		else $error("instruction ack dropped without exit");
	AST_DACK_SET: assert property (bus_valid && data_access_begin_q |=> data_burst_ack)
		else $error("data ack not set after data start");
	AST_ACK_DELAY: assert property (
		instr_ack_delayed == $past(instr_burst_ack) && data_ack_delayed == $past(data_burst_ack))
		else $error("delayed ack does not follow ack");
	AST_DACKI_COVERS: assert property (data_burst_ack |-> data_ack_internal)
		else $error("internal data ack below external ack");
	AST_IPHASE_SEQ: assert property (
		$rose(iq[0]) && !iq[1] && !iq[2] |-> s_iphase_run)
		else $error("instruction phase flags out of sequence");
	AST_DPHASE_SEQ: assert property (
		$rose(dq[0]) && !dq[1] && !dq[2]
		|-> dq[0] ##1 dq[1] ##1 dq[2] ##1 !dq[0])
		else $error("data phase flags out of sequence");
	// a refresh that stays pending restarts the begin term once; only
	// the first cycle of the run opens the check
	AST_PREEMPT_RUN: assert property (
		preempt_begin && !wp_a |=> s_preempt_run)
		else $error("preempt did not lead into precharge");
	AST_PRECH_TWO: assert property ($rose(pc1) |=> pc2 ##1 !pc2)
		else $error("precharge second flag wrong");
	AST_PRECH_REFRESH: assert property (
		!pc1 && refresh_final_phase_i |=> pc1)
		else $error("refresh end did not start precharge");
	AST_PRECH_INSTR: assert property (
		!pc1 && instr_burst_ack && instr_access_leave_i |=> pc1)
		else $error("instruction exit did not start precharge");
	AST_LOAD_ONE: assert property (
		load_strobe && !instr_burst_ack && !data_ack_internal |=> !load_strobe || pc1)
		else $error("load strobe longer than one cycle");
	AST_LOAD_FIRST: assert property (
		!iq[0] && !data_ack_internal && !instr_burst_ack && instr_request_i
		|=> cnt[0] == $past(load_addr_i[0]))
		else $error("first request cycle did not load counter");
	// an instruction request must not reload the counters mid data access
	AST_LOAD_HELD: assert property (
		data_ack_internal && !pc1 && bank_count_i == '0
		|=> cnt[0] == $past(cnt[0]) && cnt[1] == $past(cnt[1]))
		else $error("counter reloaded during data access");
	AST_DATA_HELD: assert property (instr_burst_ack && !data_burst_ack |=> !data_burst_ack)
		else $error("data ack set while instruction ack held");
	AST_IDLE_TO_INSTR_ROW_STROBE_STATE: assert property (
		((state == idbc_pkg::ST_IDLE && !next_pc1) and s_istart)
		|=> state == idbc_pkg::ST_INSTR_ROW_STROBE_STATE)
		else $error("start did not enter instruction row state");
	AST_UPPER_GATE: assert property (
		!load_strobe && !cnt[0][0]
		|=> bank_addr_o[0] == $past(bank_addr_o[0]))
		else $error("bank address moved with phase bit low");
	AST_DATA_ACCESS_LEAVE_REFRESH: assert property (
		data_ack_internal && !dq[0] && !pc1 && !pc2 && refresh_pending_i
		&& !(bus_valid && data_access_begin_q) |=> !data_burst_ack)
		else $error("data ack held with refresh pending after setup");

endmodule : idbc_ctrl

//--- dv/idbc_proc_model.sv
// processor-side model: bus validity and registered burst request
`timescale 1ns/100ps
module idbc_proc_model (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	// processor intent
	input wire logic bus_valid_i,
	input wire logic burst_req_i,
	// toward the controller
	output logic bus_invalid_o,
	output logic burst_req_delayed_o
);
	logic next_burst_req_delayed;

	// the raw request arrives late in the cycle, so only a registered copy
	// is offered to the controller
	assign bus_invalid_o = ~bus_valid_i;
	always_comb begin
		next_burst_req_delayed = sys_rst_i ? 1'b0 : burst_req_i;
	end
	always_ff @(posedge ref_clk_i) begin
		burst_req_delayed_o <= next_burst_req_delayed;
	end
endmodule : idbc_proc_model

//--- dv/testbench.sv
// self-checking bench for the burst controller
`timescale 1ns/100ps
module testbench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic bus_ok = 1'b1;
	logic breq = 1'b0;
	logic bus_inv, breq_d, ibeg = 1'b0, dbeg = 1'b0, ileave = 1'b0;
	logic instr_request = 1'b0, data_request = 1'b0, wr = 1'b0, hit = 1'b0;
	logic rfp = 1'b0, rfin = 1'b0;
	logic [1:0] cnt = 2'h0;
	logic [idbc_pkg::CNT_W-1:0] ld_addr [idbc_pkg::BANK_COUNT];
	logic iack, dack, dint, iackd, dackd, pc1, pc2, row;
	logic [2:0] iph, dph;
	logic [1:0] wps, lsb;
	idbc_pkg::idbc_state_t st;
	logic [idbc_pkg::BANK_ADDR_W-1:0] ba [idbc_pkg::BANK_COUNT];
	int bad_count = 0;
	int n_tests = 0;
	int cycles = 0;

	idbc_proc_model proc (.ref_clk_i(clk), .sys_rst_i(rst),
		.bus_valid_i(bus_ok), .burst_req_i(breq),
		.bus_invalid_o(bus_inv), .burst_req_delayed_o(breq_d));
	idbc_ctrl dut (.ref_clk_i(clk), .sys_rst_i(rst),
		.bus_invalid_i(bus_inv), .instr_request_i(instr_request),
		.data_request_i(data_request), .data_write_i(wr),
		.data_burst_req_delayed_i(breq_d), .instr_access_begin_i(ibeg),
		.data_access_begin_i(dbeg), .instr_access_leave_i(ileave),
		.instr_block_hit_i(hit), .refresh_pending_i(rfp),
		.refresh_final_phase_i(rfin), .bank_count_i(cnt),
		.load_addr_i(ld_addr), .instr_burst_ack_o(iack),
		.data_burst_ack_o(dack), .data_ack_internal_o(dint),
		.instr_ack_delayed_o(iackd), .data_ack_delayed_o(dackd),
		.instr_init_phase_o(iph), .data_init_phase_o(dph),
		.write_preempt_stage_o(wps), .precharge_first_o(pc1),
		.precharge_second_o(pc2), .row_strobe_o(row),
		.access_state_o(st), .bank_addr_o(ba), .bank_lsb_o(lsb));

	initial begin
		forever #2.5 clk = ~clk;
	end

	task automatic tick;
		@(posedge clk);
		#1;
	endtask : tick

	task automatic check(input string name, input logic [7:0] seen,
		input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
			bad_count++;
		end
	endtask : check

	task automatic end_sim;
		if (bad_count == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_sim

	task automatic t_refuse;
		bus_ok = 1'b0;
		ibeg = 1'b1;
		tick;
		ibeg = 1'b0;
		bus_ok = 1'b1;
		check("iack", iack, 8'h00);
		check("iphase", iph, 8'h00);
	endtask : t_refuse

	task automatic t_instr;
		ibeg = 1'b1;
		tick;
		ibeg = 1'b0;
		dbeg = 1'b1;
		check("iack", iack, 8'h01);
		check("state", st, 8'h02);
		check("iphase", iph, 8'h01);
		tick;
		dbeg = 1'b0;
		check("dack", dack, 8'h00);
		check("iphase", iph, 8'h03);
		check("iack_d", iackd, 8'h01);
		tick;
		check("iphase", iph, 8'h07);
		tick;
		check("iphase", iph, 8'h00);
		check("state", st, 8'h04);
		check("row", row, 8'h01);
		ileave = 1'b1;
		tick;
		ileave = 1'b0;
		check("iack", iack, 8'h00);
		check("pc1", pc1, 8'h01);
		check("row", row, 8'h00);
		tick;
		check("pc2", pc2, 8'h01);
		check("state", st, 8'h01);
	endtask : t_instr

	task automatic t_data;
		dbeg = 1'b1;
		tick;
		dbeg = 1'b0;
		check("dack", dack, 8'h01);
		check("dint", dint, 8'h01);
		check("dphase", dph, 8'h01);
		tick;
		check("dack_d", dackd, 8'h01);
		check("dphase", dph, 8'h03);
		repeat (2) tick;
		check("dphase", dph, 8'h00);
		check("dack", dack, 8'h01);
		rfp = 1'b1;
		tick;
		rfp = 1'b0;
		check("dack", dack, 8'h00);
		check("pc1", pc1, 8'h01);
		repeat (2) tick;
		rfin = 1'b1;
		tick;
		rfin = 1'b0;
		check("pc1", pc1, 8'h01);
		repeat (2) tick;
	endtask : t_data

	task automatic t_count;
		ld_addr[0] = 8'h5B;
		ld_addr[1] = 8'hA4;
		instr_request = 1'b1;
		tick;
		instr_request = 1'b0;
		check("ba0", ba[0], 8'h2D);
		check("lsb", lsb, 8'h01);
		cnt = 2'h3;
		tick;
		check("ba0", ba[0], 8'h2E);
		check("ba1", ba[1], 8'h52);
		check("lsb", lsb, 8'h02);
		bus_ok = 1'b0;
		tick;
		cnt = 2'h0;
		bus_ok = 1'b1;
		check("ba0", ba[0], 8'h2E);
		check("lsb", lsb, 8'h02);
	endtask : t_count

	task automatic t_preempt;
		wr = 1'b1;
		breq = 1'b1;
		dbeg = 1'b1;
		tick;
		dbeg = 1'b0;
		instr_request = 1'b1;
		check("dack", dack, 8'h01);
		repeat (3) tick;
		instr_request = 1'b0;
		rfp = 1'b1;
		check("ba0", ba[0], 8'h2E);
		check("dphase", dph, 8'h00);
		tick;
		check("wps", wps, 8'h01);
		check("dack", dack, 8'h00);
		check("dint", dint, 8'h01);
		tick;
		check("wps", wps, 8'h03);
		check("dint", dint, 8'h01);
		check("pc1", pc1, 8'h00);
		tick;
		rfp = 1'b0;
		wr = 1'b0;
		breq = 1'b0;
		check("pc1", pc1, 8'h01);
		check("wps", wps, 8'h00);
		check("dint", dint, 8'h00);
		repeat (2) tick;
	endtask : t_preempt

	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			bad_count++;
			end_sim;
		end
	end

	initial begin
		ld_addr[0] = 8'h00;
		ld_addr[1] = 8'h00;
		repeat (6) @(posedge clk);
		#1;
		rst = 1'b0;
		check("state", st, 8'h01);
		check("wps", wps, 8'h00);
		t_refuse;
		t_instr;
		t_data;
		t_count;
		t_preempt;
		end_sim;
	end
endmodule : testbench
